// ==== src/sarc_pkg.sv ====
`default_nettype none
package sarc_pkg;
  localparam int SARC_NUM_CH = 16;
  localparam int SARC_ROW_AW = 6;
  localparam int SARC_NUM_ROWS = 64;
  localparam int SARC_GRP_AW = 5;
  localparam int SARC_NUM_GRPS = 32;
  localparam int SARC_NUM_STRB_ROWS = 8;
  // AXI byte offsets
  localparam logic [7:0] SARC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SARC_ADDR_OFS = 8'h04;
  localparam logic [7:0] SARC_STRB_OFS = 8'h08;
  localparam logic [7:0] SARC_STAT_OFS = 8'h0C;
  localparam logic [7:0] SARC_IRQ_OFS = 8'h10;
  localparam logic [7:0] SARC_MASK_OFS = 8'h14;
  localparam logic [7:0] SARC_CMP_OFS = 8'h18;
  // CTRL fields
  localparam int SARC_CTRL_ROWEN_BIT = 0;
  localparam int SARC_CTRL_RAMP_BIT = 1;
  localparam int SARC_CTRL_POL_BIT = 2;
  localparam int SARC_CTRL_RAW_BIT = 3;
  localparam int SARC_CTRL_TERM_LSB = 4;
  // ADDR fields
  localparam int SARC_ADDR_ROW_LSB = 0;
  localparam int SARC_ADDR_GRP_LSB = 8;
  // IRQ status bits
  localparam int SARC_IRQ_TRIG_BIT = 0;
  localparam int SARC_IRQ_CARRY_BIT = 1;
  localparam logic [31:0] SARC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SARC_ADDR_RST = 32'h0000_0000;
  localparam logic [7:0] SARC_STRETCH_RST = 8'h04;
  localparam logic [1:0] SARC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SARC_RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic row_readout_enable;
    logic conversion_ramp_start;
    logic trigger_polarity_sel;
    logic trigger_output_path_sel;
    logic term_10k_select;
    logic term_1k_select;
    logic term_100_select;
  } sarc_ctrl_t;
  typedef struct packed {
    logic [SARC_GRP_AW-1:0] group_address;
    logic [SARC_ROW_AW-1:0] row_address;
  } sarc_addr_t;
endpackage
`default_nettype wire

// ==== src/sarc_chan.sv ====
`default_nettype none
module sarc_chan
  import sarc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hit_i,
  input wire logic polarity_i,
  input wire logic raw_sel_i,
  input wire logic [7:0] stretch_i,
  output logic trig_o
);
  logic hit;
  logic [7:0] cnt_q, cnt_d;
  logic prev_q, prev_d;
  logic shot;

  // Polarity 0 watches negative-going input
  assign hit = polarity_i ? hit_i : ~hit_i;

  always_comb
  begin
    prev_d = hit;
    cnt_d = cnt_q;
    if (hit && !prev_q)
      cnt_d = stretch_i;
    else if (cnt_q != 8'h00)
      cnt_d = cnt_q - 8'h01;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 8'h00;
      // Idle level under the reset polarity, so no false edge after reset
      prev_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      prev_q <= prev_d;
    end
  end

  assign shot = cnt_q != 8'h00;
  assign trig_o = raw_sel_i ? hit : shot;
endmodule // sarc_chan
`default_nettype wire

// ==== src/sarc_top.sv ====
`default_nettype none
// Summary of operation
// - Row readout outputs are driven only while the row readout enable is set; a 6-bit address picks 1 of 64 rows.
// - A 5-bit group address picks one of 32 groups of 16 samples within a row, for random access after a trigger.
// - Odd row enables gate the first sample strobe and even row enables gate the second.
// - Three independent termination bits switch in 100, 1k and 10k; all clear leaves the input open.
// - Trigger path select 1 routes the raw comparator, 0 the stretched one-shot.
// - The trigger OR output is the OR of all 16 channel triggers.
// - Trigger polarity input 0 selects negative-going, 1 positive-going signals.
module sarc_top
  import sarc_pkg::*;
#(
  parameter int NUM_CH = SARC_NUM_CH,
  parameter int RAMP_W = 10
)
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic FIRST_SAMPLE_STROBE_I,
  input wire logic SECOND_SAMPLE_STROBE_I,
  input wire logic [NUM_CH-1:0] SAMPLE_LEVEL_I,
  input wire logic [NUM_CH-1:0] TRIG_HIT_I,
  input wire logic OSCILLATOR_CARRY_OUT_I,
  output logic [SARC_NUM_STRB_ROWS-1:0] ROW_SAMPLE_O,
  output logic [NUM_CH-1:0] TOP_COMPARATOR_O,
  output logic [NUM_CH-1:0] TRIGGER_O,
  output logic TRIGGER_OR_O,
  output logic OSCILLATOR_CARRY_MONITOR_O,
  output logic [2:0] TERM_SELECT_O,
  output logic [SARC_ROW_AW-1:0] ROW_ADDR_O,
  output logic [SARC_GRP_AW-1:0] GROUP_ADDR_O,
  output logic IRQ_O
);
  if (NUM_CH != SARC_NUM_CH || RAMP_W < 1 || RAMP_W > 16)
  begin : g_param_check
    $error("sarc_top: unsupported parameters");
  end

  sarc_ctrl_t ctrl_q, ctrl_d;
  sarc_addr_t addr_q, addr_d;
  logic [SARC_NUM_STRB_ROWS-1:0] strb_en_q, strb_en_d;
  logic [1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, awrdy_q, wrdy_q, arrdy_q;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [RAMP_W-1:0] ramp_q, ramp_d;
  logic [SARC_NUM_STRB_ROWS-1:0] row_sample_q, row_sample_d;
  logic [NUM_CH-1:0] cmp_q, cmp_d, trig_q, trig_raw;
  logic trig_or_q, carry_q, irq_q;
  logic [2:0] term_q;
  logic [SARC_ROW_AW-1:0] row_o_q;
  logic [SARC_GRP_AW-1:0] grp_o_q;
  logic [7:0] stretch_q, stretch_d;
  logic wr_go, rd_go, trig_evt, carry_evt;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      sarc_chan u_chan (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .hit_i(TRIG_HIT_I[g]),
        .polarity_i(ctrl_q.trigger_polarity_sel),
        .raw_sel_i(ctrl_q.trigger_output_path_sel),
        .stretch_i(stretch_q),
        .trig_o(trig_raw[g])
      );
    end
  endgenerate

  // Write address and data may arrive in either order
  assign wr_go = aw_q && w_q && !bv_q;
  assign rd_go = S_AXI_ARVALID_I && !rv_q;
  assign trig_evt = |trig_raw;
  assign carry_evt = OSCILLATOR_CARRY_OUT_I && !carry_q;

  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bv_d = bv_q;
    bresp_d = bresp_q;
    rv_d = rv_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    strb_en_d = strb_en_q;
    irq_mask_d = irq_mask_q;
    stretch_d = stretch_q;
    irq_st_d = irq_st_q;
    if (S_AXI_AWVALID_I && !aw_q)
    begin
      aw_d = 1'b1;
      awaddr_d = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && !w_q)
    begin
      w_d = 1'b1;
      wdata_d = S_AXI_WDATA_I;
    end
    if (bv_q && S_AXI_BREADY_I)
      bv_d = 1'b0;
    if (rv_q && S_AXI_RREADY_I)
      rv_d = 1'b0;
    if (wr_go)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      bresp_d = SARC_RESP_OKAY;
      unique case (awaddr_q)
        SARC_CTRL_OFS:
          ctrl_d = sarc_ctrl_t'({wdata_q[SARC_CTRL_ROWEN_BIT], wdata_q[SARC_CTRL_RAMP_BIT],
                                 wdata_q[SARC_CTRL_POL_BIT], wdata_q[SARC_CTRL_RAW_BIT],
                                 wdata_q[SARC_CTRL_TERM_LSB+2], wdata_q[SARC_CTRL_TERM_LSB+1],
                                 wdata_q[SARC_CTRL_TERM_LSB]});
        SARC_ADDR_OFS:
          addr_d = sarc_addr_t'({wdata_q[SARC_ADDR_GRP_LSB +: SARC_GRP_AW],
                                 wdata_q[SARC_ADDR_ROW_LSB +: SARC_ROW_AW]});
        SARC_STRB_OFS:
        begin
          strb_en_d = wdata_q[SARC_NUM_STRB_ROWS-1:0];
          stretch_d = wdata_q[15:8];
        end
        SARC_MASK_OFS:
          irq_mask_d = wdata_q[1:0];
        default:
          bresp_d = SARC_RESP_SLVERR;
      endcase
    end
    if (rd_go)
    begin
      rv_d = 1'b1;
      rresp_d = SARC_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case (S_AXI_ARADDR_I)
        SARC_CTRL_OFS:
          rdata_d[6:0] = {term_q, ctrl_q.trigger_output_path_sel, ctrl_q.trigger_polarity_sel,
                          ctrl_q.conversion_ramp_start, ctrl_q.row_readout_enable};
        SARC_ADDR_OFS:
          rdata_d[12:0] = {addr_q.group_address, 2'h0, addr_q.row_address};
        SARC_STRB_OFS:
          rdata_d[15:0] = {stretch_q, strb_en_q};
        SARC_STAT_OFS:
          rdata_d[31:0] = {8'h00, trig_q, row_sample_q};
        SARC_IRQ_OFS:
        begin
          rdata_d[1:0] = irq_st_q;
          irq_st_d = 2'h0;
        end
        SARC_MASK_OFS:
          rdata_d[1:0] = irq_mask_q;
        SARC_CMP_OFS:
          rdata_d[31:0] = {{(16-RAMP_W){1'b0}}, ramp_q, cmp_q};
        default:
          rresp_d = SARC_RESP_SLVERR;
      endcase
    end
    // Set wins over read-clear
    if (trig_evt)
      irq_st_d[SARC_IRQ_TRIG_BIT] = 1'b1;
    if (carry_evt)
      irq_st_d[SARC_IRQ_CARRY_BIT] = 1'b1;
  end

  always_comb
  begin
    // Ramp runs only while the start bit is held
    if (ctrl_q.conversion_ramp_start)
      ramp_d = (&ramp_q) ? ramp_q : ramp_q + 1'b1;
    else
      ramp_d = '0;
    for (int i = 0; i < NUM_CH; i++)
      cmp_d[i] = ctrl_q.row_readout_enable && ctrl_q.conversion_ramp_start &&
                 (ramp_q >= SAMPLE_LEVEL_I[i] * RAMP_W'(1));
    for (int r = 0; r < SARC_NUM_STRB_ROWS; r++)
      row_sample_d[r] = strb_en_q[r] &&
                        (r[0] ? SECOND_SAMPLE_STROBE_I : FIRST_SAMPLE_STROBE_I);
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      bv_q <= 1'b0;
      bresp_q <= 2'h0;
      rv_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      ctrl_q <= sarc_ctrl_t'(SARC_CTRL_RST[6:0]);
      addr_q <= sarc_addr_t'(SARC_ADDR_RST[10:0]);
      strb_en_q <= '0;
      irq_mask_q <= 2'h0;
      irq_st_q <= 2'h0;
      stretch_q <= SARC_STRETCH_RST;
      ramp_q <= '0;
      cmp_q <= '0;
      row_sample_q <= '0;
      trig_q <= '0;
      trig_or_q <= 1'b0;
      carry_q <= 1'b0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      arrdy_q <= 1'b1;
      irq_q <= 1'b0;
      term_q <= 3'h0;
      row_o_q <= '0;
      grp_o_q <= '0;
    end
    else
    begin
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bv_q <= bv_d;
      bresp_q <= bresp_d;
      rv_q <= rv_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      strb_en_q <= strb_en_d;
      irq_mask_q <= irq_mask_d;
      irq_st_q <= irq_st_d;
      stretch_q <= stretch_d;
      ramp_q <= ramp_d;
      cmp_q <= cmp_d;
      row_sample_q <= row_sample_d;
      trig_q <= trig_raw;
      trig_or_q <= trig_evt;
      carry_q <= OSCILLATOR_CARRY_OUT_I;
      // Ready flops mirror the holding flops so the pins come from registers
      awrdy_q <= !aw_d;
      wrdy_q <= !w_d;
      arrdy_q <= !rv_d;
      irq_q <= |(irq_st_d & irq_mask_q);
      term_q <= {ctrl_q.term_10k_select, ctrl_q.term_1k_select, ctrl_q.term_100_select};
      // Addresses only reach the pins while readout is enabled
      row_o_q <= ctrl_q.row_readout_enable ? addr_q.row_address : '0;
      grp_o_q <= ctrl_q.row_readout_enable ? addr_q.group_address : '0;
    end
  end

  assign S_AXI_AWREADY_O = awrdy_q;
  assign S_AXI_WREADY_O = wrdy_q;
  assign S_AXI_BVALID_O = bv_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = arrdy_q;
  assign S_AXI_RVALID_O = rv_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign ROW_SAMPLE_O = row_sample_q;
  assign TOP_COMPARATOR_O = cmp_q;
  assign TRIGGER_O = trig_q;
  assign TRIGGER_OR_O = trig_or_q;
  assign OSCILLATOR_CARRY_MONITOR_O = carry_q;
  assign TERM_SELECT_O = term_q;
  assign ROW_ADDR_O = row_o_q;
  assign GROUP_ADDR_O = grp_o_q;
  assign IRQ_O = irq_q;
endmodule // sarc_top
`default_nettype wire

// ==== verif/sarc_top_checker.sv ====
`default_nettype none
module sarc_top_checker
  import sarc_pkg::*;
#(
  parameter int NUM_CH = SARC_NUM_CH
)
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic FIRST_SAMPLE_STROBE_I,
  input wire logic SECOND_SAMPLE_STROBE_I,
  input wire logic OSCILLATOR_CARRY_OUT_I,
  input wire logic OSCILLATOR_CARRY_MONITOR_O,
  input wire logic TRIGGER_OR_O,
  input wire logic [NUM_CH-1:0] TRIGGER_O,
  input wire logic [SARC_NUM_STRB_ROWS-1:0] ROW_SAMPLE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered outputs hold reset values for a few edges after release
  logic [1:0] age_q, age_d;
  always_comb age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
      age_q <= 2'h0;
    else
      age_q <= age_d;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  sequence s_rd_taken;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence
  sequence s_rd_answer;
    ##[1:2] S_AXI_RVALID_O;
  endsequence
  AST_ODD_ROWS: assert property (|(ROW_SAMPLE_O & 8'h55) |-> $past(FIRST_SAMPLE_STROBE_I))
    else $error("odd row sampled without first strobe");
  AST_EVEN_ROWS: assert property (|(ROW_SAMPLE_O & 8'hAA) |-> $past(SECOND_SAMPLE_STROBE_I))
    else $error("even row sampled without second strobe");
  AST_TRIG_OR: assert property (age_q == 2'h3 |-> TRIGGER_OR_O == |TRIGGER_O)
    else $error("trigger or differs from channel triggers");
  AST_CARRY_MON: assert property (age_q == 2'h3 |-> OSCILLATOR_CARRY_MONITOR_O == $past(OSCILLATOR_CARRY_OUT_I))
    else $error("carry monitor does not follow carry");
  AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
    else $error("write response dropped");
  AST_R_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read response dropped or changed");
  AST_AR_BLOCK: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read address accepted during response");
  AST_R_LATENCY: assert property (s_rd_taken |-> s_rd_answer)
    else $error("read response late");
endmodule // sarc_top_checker
bind sarc_top sarc_top_checker #(.NUM_CH(NUM_CH)) u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .FIRST_SAMPLE_STROBE_I(FIRST_SAMPLE_STROBE_I),
  .SECOND_SAMPLE_STROBE_I(SECOND_SAMPLE_STROBE_I), .OSCILLATOR_CARRY_OUT_I(OSCILLATOR_CARRY_OUT_I),
  .OSCILLATOR_CARRY_MONITOR_O(OSCILLATOR_CARRY_MONITOR_O), .TRIGGER_OR_O(TRIGGER_OR_O),
  .TRIGGER_O(TRIGGER_O), .ROW_SAMPLE_O(ROW_SAMPLE_O));
`default_nettype wire

// ==== verif/sarc_fpga_model.sv ====
`default_nettype none
module sarc_fpga_model
  import sarc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic first_o,
  output logic second_o,
  output logic carry_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q, cnt_d;
  always_comb cnt_d = run_i ? cnt_q + 4'h1 : cnt_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_d;
  // One shared cycle between odd and even strobes keeps the windows seamless
  assign first_o = run_i && (cnt_q[2:0] <= 3'h4);
  assign second_o = run_i && (cnt_q[2:0] >= 3'h4);
  // Carry stalls with the strobes, so it only rises while running
  assign carry_o = cnt_q[3];
endmodule // sarc_fpga_model
`default_nettype wire

// ==== verif/tb_sample_array_readout_control.sv ====
`default_nettype none
module tb_sample_array_readout_control
  import sarc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] e; logic [31:0] m; logic [1:0] r;} sarc_exp_t;
  logic clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, run = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00, rows;
  logic [31:0] wd = 32'h0, rdat;
  logic [15:0] lvl = 16'h0, hit = 16'h0, cmp, trg;
  logic awr, wr, bv, arr, rv, tor, cmon, irq, fst, snd, cry;
  logic [1:0] bresp, rresp;
  logic [2:0] term;
  logic [5:0] rowa;
  logic [4:0] grpa;
  sarc_exp_t q[$];
  sarc_exp_t ex;
  int n_mismatch = 0, n_compared = 0;
  initial forever #5 clk = ~clk;
  sarc_top u_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .FIRST_SAMPLE_STROBE_I(fst),
    .SECOND_SAMPLE_STROBE_I(snd), .SAMPLE_LEVEL_I(lvl), .TRIG_HIT_I(hit), .OSCILLATOR_CARRY_OUT_I(cry),
    .ROW_SAMPLE_O(rows), .TOP_COMPARATOR_O(cmp), .TRIGGER_O(trg), .TRIGGER_OR_O(tor),
    .OSCILLATOR_CARRY_MONITOR_O(cmon), .TERM_SELECT_O(term), .ROW_ADDR_O(rowa), .GROUP_ADDR_O(grpa),
    .IRQ_O(irq));
  sarc_fpga_model u_fpga (.clk_i(clk), .rst_n_i(rst_n), .run_i(run), .first_o(fst), .second_o(snd),
    .carry_o(cry));
  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic hang();
    $display("[ERR] handshake expected answer seen none");
    n_mismatch++;
    stop_test();
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = SARC_RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (awr === 1'h1) awv <= 1'h0;
      if (wr === 1'h1) wv <= 1'h0;
      if (n > 50) hang();
    end
    while (bv !== 1'h1);
    br <= 1'h0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  // Expectation goes on the queue; the monitor below does the compare
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
    input logic [1:0] er = SARC_RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    q.push_back('{e, m, er});
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (arr === 1'h1) arv <= 1'h0;
      if (n > 50) hang();
    end
    while (rv !== 1'h1);
    rr <= 1'h0;
  endtask
  always @(posedge clk)
    if (rv === 1'h1 && rr && q.size() > 0)
    begin
      ex = q.pop_front();
      chk("rdata", ex.e & ex.m, rdat & ex.m);
      chk("rresp", 32'(ex.r), 32'(rresp));
    end
  initial
  begin
    logic [31:0] v;
    logic [7:0] en;
    logic [1:0] fs;
    int hi;
    void'($urandom(17));
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    lvl <= 16'($urandom);
    rreg(SARC_CTRL_OFS, SARC_CTRL_RST);
    rreg(SARC_STRB_OFS, 32'(SARC_STRETCH_RST) << 8);
    rreg(8'h1C, 32'h0, 32'hFFFFFFFF, SARC_RESP_SLVERR);
    wreg(8'h20, 32'hFFFFFFFF, SARC_RESP_SLVERR);
    for (int t = 0; t < 8; t++)
    begin
      wreg(SARC_CTRL_OFS, 32'(t) << SARC_CTRL_TERM_LSB);
      repeat (2) @(posedge clk);
      #1 chk("term", 32'(t), 32'(term));
    end
    rreg(SARC_CTRL_OFS, 32'h70, 32'h7F);
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 32'h1F3F : $urandom & 32'h1F3F;
      wreg(SARC_CTRL_OFS, 32'h0);
      wreg(SARC_ADDR_OFS, v);
      repeat (2) @(posedge clk);
      #1 chk("addr_off", 32'h0, 32'({grpa, rowa}));
      wreg(SARC_CTRL_OFS, 32'h1);
      repeat (2) @(posedge clk);
      #1 chk("row_addr", v & 32'h3F, 32'(rowa));
      chk("grp_addr", v >> 8, 32'(grpa));
      chk("cmp_idle", 32'h0, 32'(cmp));
    end
    wreg(SARC_CTRL_OFS, 32'h3);
    // First latched compare still sees a zero ramp, so it shows the inverted levels
    #1 chk("cmp_first", {16'h0000, ~lvl}, 32'(cmp));
    repeat (6) @(posedge clk);
    #1 chk("cmp_on", 32'hFFFF, 32'(cmp));
    rreg(SARC_CMP_OFS, 32'hFFFF, 32'hFFFF);
    wreg(SARC_CTRL_OFS, 32'h2);
    repeat (3) @(posedge clk);
    #1 chk("cmp_off", 32'h0, 32'(cmp));
    // Row five is held for conversion and stays out of sampling
    en = 8'($urandom) & 8'hEF;
    wreg(SARC_STRB_OFS, {16'h0, 8'h04, en});
    @(posedge clk);
    run <= 1'h1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 20; k++)
    begin
      @(posedge clk);
      fs = {snd, fst};
      #1 chk("row_sample", 32'(en & {4{fs}}), 32'(rows));
    end
    run <= 1'h0;
    for (int p = 0; p < 2; p++)
    begin
      wreg(SARC_CTRL_OFS, 32'h8 | (32'(p) << SARC_CTRL_POL_BIT));
      @(posedge clk);
      v = $urandom & 32'hFFFF;
      hit <= v[15:0];
      repeat (4) @(posedge clk);
      #1 chk("trig_raw", {16'h0000, p ? v[15:0] : ~v[15:0]}, 32'(trg));
      chk("trig_or", 32'(|(p ? v[15:0] : ~v[15:0])), 32'(tor));
    end
    @(posedge clk);
    hit <= 16'h0;
    wreg(SARC_CTRL_OFS, 32'h4);
    repeat (4) @(posedge clk);
    #1 chk("or_idle", 32'h0, 32'(tor));
    @(posedge clk);
    hit <= 16'h0020;
    hi = 0;
    repeat (16)
    begin
      @(posedge clk);
      if (trg[5] === 1'h1) hi++;
    end
    chk("oneshot_len", 32'(SARC_STRETCH_RST), 32'(hi));
    #1 chk("oneshot_end", 32'h0, 32'(trg));
    wreg(SARC_CTRL_OFS, 32'hC);
    hit <= 16'h0;
    rreg(SARC_IRQ_OFS, 32'h0, 32'h0);
    wreg(SARC_MASK_OFS, 32'h3);
    for (int j = 0; j < 3; j++)
    begin
      if (j == 2) wreg(SARC_MASK_OFS, 32'h2);
      repeat (3) @(posedge clk);
      #1 chk("irq_idle", 32'h0, 32'(irq));
      @(posedge clk);
      hit <= 16'h0100;
      repeat (2) @(posedge clk);
      hit <= 16'h0;
      repeat (4) @(posedge clk);
      #1 chk("irq_trig", 32'(j < 2), 32'(irq));
      if (j < 2) rreg(SARC_IRQ_OFS, 32'h1, 32'h3);
    end
    @(posedge clk);
    run <= 1'h1;
    repeat (20) @(posedge clk);
    run <= 1'h0;
    repeat (4) @(posedge clk);
    #1 chk("irq_carry", 32'h1, 32'(irq));
    rreg(SARC_IRQ_OFS, 32'h3, 32'h3);
    repeat (4) @(posedge clk);
    #1 chk("irq_clear", 32'h0, 32'(irq));
    // Reset after the run has stopped: no false trigger edge may follow the release
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rreg(SARC_CTRL_OFS, SARC_CTRL_RST);
    rreg(SARC_IRQ_OFS, 32'h0);
    #1 chk("irq_rst", 32'h0, 32'(irq));
    chk("row_addr_rst", 32'h0, 32'({grpa, rowa}));
    stop_test();
  end
endmodule // tb_sample_array_readout_control
`default_nettype wire
